// *** rtl/obd_option_decoder.v ***
// Behaviour
// [R01] Fetch config bytes after each reset, then apply
// [R02] Detector byte bit four written as one
// [R03] Mode 10: interrupt and reset thresholds
// [R04] Mode 11: reset only, fourteen levels
// [R05] Mode 01: interrupt only, same fourteen levels
// [R06] Top bit and mode bit zero: detector off
// [R07] Clock byte bits five, four written 10
// [R08] Flash speed decode, code 01 prohibited
// [R09] Oscillator frequency within flash mode limit
// [R10] Oscillator frequency code decode
// [R11] Decoded fields latched once, held until reset
//
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "obd_consts.vh"

module obd_option_decoder (
    input  wire                  clk_i,
    input  wire                  rst_i,
    output reg                   nv_req_o,
    output reg  [19:0]           nv_addr_o,
    input  wire                  nv_ack_i,
    input  wire [7:0]            nv_data_i,
    output reg                   cfg_valid_o,
    output reg                   det_rst_en_o,
    output reg                   det_int_en_o,
    output reg  [3:0]            det_rst_lvl_o,
    output reg  [3:0]            det_int_lvl_o,
    output reg  [1:0]            flash_mode_o,
    output reg  [4:0]            osc_freq_mhz_o,
    output reg                   cfg_error_o,
    input  wire [11:0]           s_axi_awaddr,
    input  wire                  s_axi_awvalid,
    output reg                   s_axi_awready,
    input  wire [31:0]           s_axi_wdata,
    input  wire [3:0]            s_axi_wstrb,
    input  wire                  s_axi_wvalid,
    output reg                   s_axi_wready,
    output reg  [1:0]            s_axi_bresp,
    output reg                   s_axi_bvalid,
    input  wire                  s_axi_bready,
    input  wire [11:0]           s_axi_araddr,
    input  wire                  s_axi_arvalid,
    output reg                   s_axi_arready,
    output reg  [31:0]           s_axi_rdata,
    output reg  [1:0]            s_axi_rresp,
    output reg                   s_axi_rvalid,
    input  wire                  s_axi_rready
);

    // ****************************************************************
    // Lookup functions
    // ****************************************************************
    // Fourteen-level code to falling-edge level index, bit 4 = valid
    function [4:0] lvl14;
        input [3:0] c;
        begin
            case (c)
                4'h3:    lvl14 = 5'h10;
                4'h2:    lvl14 = 5'h11;
                4'h7:    lvl14 = 5'h12;
                4'h6:    lvl14 = 5'h13;
                4'h5:    lvl14 = 5'h14;
                4'hb:    lvl14 = 5'h15;
                4'ha:    lvl14 = 5'h16;
                4'h9:    lvl14 = 5'h17;
                4'hf:    lvl14 = 5'h18;
                4'he:    lvl14 = 5'h19;
                4'hd:    lvl14 = 5'h1a;
                4'h4:    lvl14 = 5'h1b;
                4'h8:    lvl14 = 5'h1c;
                4'hc:    lvl14 = 5'h1d;
                default: lvl14 = 5'h00;
            endcase
        end
    endfunction

    // Combined mode interrupt level index, bit 4 = valid
    function [4:0] int_lvl;
        input [3:0] c;
        begin
            case (c)
                4'h2:    int_lvl = 5'h11;
                4'h1:    int_lvl = 5'h12;
                4'h0:    int_lvl = 5'h19;
                4'h6:    int_lvl = 5'h13;
                4'h5:    int_lvl = 5'h14;
                4'h4:    int_lvl = 5'h1b;
                4'ha:    int_lvl = 5'h16;
                4'h9:    int_lvl = 5'h17;
                4'h8:    int_lvl = 5'h1c;
                4'he:    int_lvl = 5'h19;
                4'hd:    int_lvl = 5'h1a;
                4'hc:    int_lvl = 5'h1d;
                default: int_lvl = 5'h00;
            endcase
        end
    endfunction

    // Oscillator code to MHz, bit 5 = valid
    function [5:0] osc_dec;
        input [3:0] c;
        begin
            case (c)
                4'h0:    osc_dec = 6'h38;
                4'h9:    osc_dec = 6'h30;
                4'h1:    osc_dec = 6'h2c;
                4'ha:    osc_dec = 6'h28;
                4'h2:    osc_dec = 6'h26;
                4'hb:    osc_dec = 6'h24;
                4'h3:    osc_dec = 6'h23;
                4'hc:    osc_dec = 6'h22;
                4'hd:    osc_dec = 6'h21;
                default: osc_dec = 6'h00;
            endcase
        end
    endfunction

    // ****************************************************************
    // Fetch sequencer
    // ****************************************************************
    localparam [2:0] S_DET   = 3'd0;
    localparam [2:0] S_GAP   = 3'd1;
    localparam [2:0] S_CLK   = 3'd2;
    localparam [2:0] S_APPLY = 3'd3;
    localparam [2:0] S_DONE  = 3'd4;

    reg  [2:0]  state_q;
    reg  [7:0]  det_byte_q;
    reg  [7:0]  clk_byte_q;
    reg  [4:0]  stat_q;
    reg         err_en_q;

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_q    <= S_DET;
            nv_req_o   <= 1'b1;
            nv_addr_o  <= `OBD_NV_DET_ADDR;
            det_byte_q <= 8'h00;
            clk_byte_q <= 8'h00;
        end
        else
        begin
            case (state_q)
                S_DET:
                    if (nv_ack_i)
                    begin
                        det_byte_q <= nv_data_i; // [R01]
                        nv_req_o   <= 1'b0;
                        state_q    <= S_GAP;
                    end
                S_GAP:
                begin
                    nv_req_o  <= 1'b1;
                    nv_addr_o <= `OBD_NV_CLK_ADDR; // [R01]
                    state_q   <= S_CLK;
                end
                S_CLK:
                    if (nv_ack_i)
                    begin
                        clk_byte_q <= nv_data_i; // [R01]
                        nv_req_o   <= 1'b0;
                        state_q    <= S_APPLY;
                    end
                S_APPLY:
                    state_q <= S_DONE;
                default:
                    state_q <= S_DONE;
            endcase
        end
    end

    // ****************************************************************
    // Decode
    // ****************************************************************
    reg         rst_en_d;
    reg         int_en_d;
    reg  [3:0]  rst_lvl_d;
    reg  [3:0]  int_lvl_d;
    reg         det_err_d;
    reg  [1:0]  fmode_d;
    reg         fsm_err_d;
    reg  [4:0]  mhz_d;
    reg         osc_err_d;
    reg         lim_err_d;
    reg  [4:0]  lim_d;
    reg  [4:0]  l14;
    reg  [4:0]  li;
    reg  [5:0]  od;
    reg  [1:0]  dms;
    reg  [4:0]  lr;

    always @*
    begin
        rst_en_d  = 1'b0;
        int_en_d  = 1'b0;
        rst_lvl_d = 4'h0;
        int_lvl_d = 4'h0;
        det_err_d = 1'b0;
        dms = {det_byte_q[`OBD_DMS_B1], det_byte_q[`OBD_DMS_B0]};
        l14 = lvl14({det_byte_q[`OBD_LLS_B1], det_byte_q[`OBD_LLS_B0],
                     det_byte_q[`OBD_HLS_B1], det_byte_q[`OBD_HLS_B0]});
        li  = int_lvl({det_byte_q[`OBD_LLS_B1], det_byte_q[`OBD_LLS_B0],
                       det_byte_q[`OBD_HLS_B1], det_byte_q[`OBD_HLS_B0]});
        lr  = lvl14({det_byte_q[`OBD_LLS_B1], det_byte_q[`OBD_LLS_B0], 2'b11});
        if (det_byte_q[`OBD_LLS_MSB])
        begin
            det_err_d = ~det_byte_q[`OBD_DMS_B0]; // [R06]
        end
        else if (dms == `OBD_DMS_INT_RST)
        begin
            rst_en_d  = li[4]; // [R03]
            int_en_d  = li[4]; // [R03]
            rst_lvl_d = lr[3:0] & {4{li[4]}}; // [R03]
            int_lvl_d = li[3:0]; // [R03]
            det_err_d = ~li[4];
        end
        else if (dms == `OBD_DMS_RST)
        begin
            rst_en_d  = l14[4]; // [R04]
            rst_lvl_d = l14[3:0]; // [R04]
            det_err_d = ~l14[4];
        end
        else if (dms == `OBD_DMS_INT)
        begin
            int_en_d  = l14[4]; // [R05]
            int_lvl_d = l14[3:0]; // [R05]
            det_err_d = ~l14[4];
        end
        else
        begin
            det_err_d = 1'b1;
        end

        fmode_d   = {clk_byte_q[`OBD_FSM_B1], clk_byte_q[`OBD_FSM_B0]};
        fsm_err_d = 1'b0;
        lim_d     = `OBD_LIM_HS;
        case (fmode_d)
            `OBD_FSM_LV: lim_d = `OBD_LIM_LV; // [R08]
            `OBD_FSM_LS: lim_d = `OBD_LIM_LS; // [R08]
            `OBD_FSM_HS: lim_d = `OBD_LIM_HS; // [R08]
            default:
            begin
                fsm_err_d = 1'b1; // [R08]
                fmode_d   = `OBD_FSM_LV;
                lim_d     = `OBD_LIM_LV;
            end
        endcase
        od        = osc_dec(clk_byte_q[`OBD_OSC_MSB:`OBD_OSC_LSB]); // [R10]
        osc_err_d = ~od[5];
        mhz_d     = od[5] ? od[4:0] : `OBD_MHZ_SAFE; // [R10]
        lim_err_d = (mhz_d > lim_d); // [R09]
    end

    // ****************************************************************
    // Latched outputs, applied once per reset except cfg_error_o, updated every cycle
    // ****************************************************************
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cfg_valid_o    <= 1'b0;
            det_rst_en_o   <= 1'b0;
            det_int_en_o   <= 1'b0;
            det_rst_lvl_o  <= 4'h0;
            det_int_lvl_o  <= 4'h0;
            flash_mode_o   <= `OBD_FSM_LV;
            osc_freq_mhz_o <= `OBD_MHZ_SAFE;
            stat_q         <= 5'h00;
            cfg_error_o    <= 1'b0;
        end
        else
        begin
            if (state_q == S_APPLY)
            begin
                cfg_valid_o    <= 1'b1; // [R01]
                det_rst_en_o   <= rst_en_d; // [R11]
                det_int_en_o   <= int_en_d; // [R11]
                det_rst_lvl_o  <= rst_lvl_d; // [R11]
                det_int_lvl_o  <= int_lvl_d; // [R11]
                flash_mode_o   <= fmode_d; // [R11]
                osc_freq_mhz_o <= mhz_d; // [R11]
                stat_q         <= {lim_err_d, osc_err_d, fsm_err_d, det_err_d, 1'b1};
            end
            cfg_error_o <= err_en_q & (|stat_q[`OBD_ST_LIM_ERR:`OBD_ST_DET_ERR]);
        end
    end

    // ****************************************************************
    // AXI4-Lite write channel
    // ****************************************************************
    reg         aw_full_q;
    reg         w_full_q;
    reg  [9:0]  aw_idx_q;
    reg  [31:0] wdata_q;
    reg         wstrb0_q;

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `OBD_RESP_OKAY;
            aw_full_q     <= 1'b0;
            w_full_q      <= 1'b0;
            aw_idx_q      <= 10'h000;
            wdata_q       <= 32'h00000000;
            wstrb0_q      <= 1'b0;
            err_en_q      <= `OBD_CTRL_RST;
        end
        else if (s_axi_bvalid)
        begin
            if (s_axi_bready)
            begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
                aw_full_q     <= 1'b0;
                w_full_q      <= 1'b0;
            end
        end
        else if (aw_full_q && w_full_q)
        begin
            s_axi_bvalid <= 1'b1;
            if (aw_idx_q == `OBD_IDX_CTRL)
            begin
                s_axi_bresp <= `OBD_RESP_OKAY;
                if (wstrb0_q)
                begin
                    err_en_q <= wdata_q[`OBD_CTRL_ERR_EN];
                end
            end
            else
            begin
                s_axi_bresp <= `OBD_RESP_SLVERR;
            end
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_idx_q      <= s_axi_awaddr[11:2];
                aw_full_q     <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                wdata_q      <= s_axi_wdata;
                wstrb0_q     <= s_axi_wstrb[0];
                w_full_q     <= 1'b1;
                s_axi_wready <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // AXI4-Lite read channel
    // ****************************************************************
    wire [9:0] ar_idx = s_axi_araddr[11:2];

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `OBD_RESP_OKAY;
        end
        else if (s_axi_rvalid)
        begin
            if (s_axi_rready)
            begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= `OBD_RESP_OKAY;
            if (ar_idx == `OBD_IDX_DET)
                s_axi_rdata <= {24'h000000, det_byte_q};
            else if (ar_idx == `OBD_IDX_CLK)
                s_axi_rdata <= {24'h000000, clk_byte_q};
            else if (ar_idx == `OBD_IDX_STAT)
                s_axi_rdata <= {27'h0000000, stat_q};
            else if (ar_idx == `OBD_IDX_CTRL)
                s_axi_rdata <= {31'h00000000, err_en_q};
            else
            begin
                s_axi_rdata <= 32'h00000000;
                s_axi_rresp <= `OBD_RESP_SLVERR;
            end
        end
    end

endmodule // obd_option_decoder

`default_nettype wire

// *** rtl/obd_consts.vh ***
`ifndef OBD_CONSTS_VH
`define OBD_CONSTS_VH

// ****************************************************************
// Non-volatile array addresses of the configuration bytes
// ****************************************************************
`define OBD_NV_AW          20
`define OBD_NV_DET_ADDR    20'h000c1
`define OBD_NV_CLK_ADDR    20'h000c2

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define OBD_IDX_DET        10'h0c1
`define OBD_IDX_CLK        10'h0c2
`define OBD_IDX_STAT       10'h0c4
`define OBD_IDX_CTRL       10'h0c5

// ****************************************************************
// Detector byte fields
// ****************************************************************
`define OBD_LLS_MSB        7
`define OBD_LLS_B1         6
`define OBD_LLS_B0         5
`define OBD_HLS_B1         3
`define OBD_HLS_B0         2
`define OBD_DMS_B1         1
`define OBD_DMS_B0         0
`define OBD_DMS_INT        2'b01
`define OBD_DMS_INT_RST    2'b10
`define OBD_DMS_RST        2'b11

// ****************************************************************
// Clock byte fields and codes
// ****************************************************************
`define OBD_FSM_B1         7
`define OBD_FSM_B0         6
`define OBD_OSC_MSB        3
`define OBD_OSC_LSB        0
`define OBD_FSM_LV         2'b00
`define OBD_FSM_LS         2'b10
`define OBD_FSM_HS         2'b11
`define OBD_LIM_LV         5'h04
`define OBD_LIM_LS         5'h08
`define OBD_LIM_HS         5'h18
`define OBD_MHZ_SAFE       5'h01

// ****************************************************************
// Status and control register layout, reset values
// ****************************************************************
`define OBD_ST_DONE        0
`define OBD_ST_DET_ERR     1
`define OBD_ST_FSM_ERR     2
`define OBD_ST_OSC_ERR     3
`define OBD_ST_LIM_ERR     4
`define OBD_CTRL_ERR_EN    0
`define OBD_CTRL_RST       1'b1
`define OBD_RESP_OKAY      2'b00
`define OBD_RESP_SLVERR    2'b10

`endif

// *** bench/obd_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "obd_consts.vh"
// ****************************************
// Load and decode checks
// ****************************************
module obd_checker (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        nv_req_o,
    input wire logic [19:0] nv_addr_o,
    input wire logic        nv_ack_i,
    input wire logic [7:0]  nv_data_i,
    input wire logic        cfg_valid_o,
    input wire logic        det_rst_en_o,
    input wire logic        det_int_en_o,
    input wire logic [3:0]  det_rst_lvl_o,
    input wire logic [3:0]  det_int_lvl_o,
    input wire logic [1:0]  flash_mode_o,
    input wire logic [4:0]  osc_freq_mhz_o
);
    logic [15:0] byte_q;
    logic        vld_q;
    wire  [7:0]  det_b = byte_q[15:8];
    wire  [7:0]  clk_b = byte_q[7:0];
    wire         fresh = cfg_valid_o && !vld_q;
    wire  [3:0]  rst_idx = {1'b0, det_b[6:5], 1'b0} + {2'h0, det_b[6:5]} - {3'h0, |det_b[6:5]};

    default clocking cb @(posedge clk_i); endclocking
    default disable iff rst_i;

    // Keeps the two fetched bytes
    always_ff @(posedge clk_i)
    begin
        vld_q <= cfg_valid_o;
        if (nv_req_o && nv_ack_i) byte_q <= {byte_q[7:0], nv_data_i};
    end

    property p_start; $fell(rst_i) |-> nv_req_o && nv_addr_o == `OBD_NV_DET_ADDR;
    endproperty
    a_start: assert property (p_start) else $error("fetch not started");
    property p_gap; nv_req_o && nv_ack_i |=> !nv_req_o;
    endproperty
    a_gap: assert property (p_gap) else $error("request not dropped");
    property p_second; nv_req_o && nv_ack_i && nv_addr_o == `OBD_NV_DET_ADDR
        |=> ##1 nv_req_o && nv_addr_o == `OBD_NV_CLK_ADDR;
    endproperty
    a_second: assert property (p_second) else $error("second fetch wrong");
    property p_apply; nv_req_o && nv_ack_i && nv_addr_o == `OBD_NV_CLK_ADDR
        |=> !cfg_valid_o ##1 cfg_valid_o;
    endproperty
    a_apply: assert property (p_apply) else $error("settings not applied");
    property p_hold; cfg_valid_o && !rst_i |=> cfg_valid_o && !nv_req_o && $stable({det_rst_en_o,
        det_int_en_o, det_rst_lvl_o, det_int_lvl_o, flash_mode_o, osc_freq_mhz_o});
    endproperty
    a_hold: assert property (p_hold) else $error("settings changed");
    property p_comb; fresh && !det_b[7] && det_b[1:0] == 2'h2 && det_b[3:2] != 2'h3
        |-> det_rst_en_o && det_int_en_o && det_rst_lvl_o == rst_idx;
    endproperty
    a_comb: assert property (p_comb) else $error("combined mode wrong");
    property p_rst; fresh && det_b == 8'h73 |-> det_rst_en_o && !det_int_en_o
        && det_rst_lvl_o == 4'hd;
    endproperty
    a_rst: assert property (p_rst) else $error("reset mode wrong");
    property p_off; fresh && det_b[7] && det_b[0] |-> !det_rst_en_o && !det_int_en_o;
    endproperty
    a_off: assert property (p_off) else $error("detector not off");
    property p_flash; fresh && clk_b[7:6] != 2'h1 |-> flash_mode_o == clk_b[7:6];
    endproperty
    a_flash: assert property (p_flash) else $error("flash mode wrong");
    property p_osc; fresh && clk_b[3:0] == 4'h9 |-> osc_freq_mhz_o == 5'h10;
    endproperty
    a_osc: assert property (p_osc) else $error("oscillator wrong");
endmodule // obd_checker

bind obd_option_decoder obd_checker u_chk (.clk_i(clk_i), .rst_i(rst_i),
    .nv_req_o(nv_req_o), .nv_addr_o(nv_addr_o), .nv_ack_i(nv_ack_i), .nv_data_i(nv_data_i),
    .cfg_valid_o(cfg_valid_o), .det_rst_en_o(det_rst_en_o), .det_int_en_o(det_int_en_o),
    .det_rst_lvl_o(det_rst_lvl_o), .det_int_lvl_o(det_int_lvl_o),
    .flash_mode_o(flash_mode_o), .osc_freq_mhz_o(osc_freq_mhz_o));
`default_nettype wire

// *** bench/obd_nv_model.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "obd_consts.vh"
// ****************************************
// Configuration array model
// ****************************************
module obd_nv_model (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        req_i,
    input  wire logic [19:0] addr_i,
    input  wire logic [3:0]  delay_i,
    input  wire logic [7:0]  det_i,
    input  wire logic [7:0]  clkb_i,
    output var  logic        ack_o,
    output var  logic [7:0]  data_o
);
    logic [3:0] wait_q;

    // Answers delay_i + 1 cycles after the request rises; data toggles when not answering
    always_ff @(posedge clk_i)
    begin
        ack_o  <= 1'b0;
        data_o <= ~data_o;
        if (rst_i || !req_i || ack_o)
        begin
            wait_q <= 4'h0;
            if (rst_i) data_o <= 8'ha5;
        end
        else if (wait_q == delay_i)
        begin
            ack_o  <= 1'b1;
            data_o <= (addr_i == `OBD_NV_DET_ADDR) ? det_i : clkb_i;
        end
        else wait_q <= wait_q + 4'h1;
    end
endmodule // obd_nv_model
`default_nettype wire

// *** bench/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Testbench
// ****************************************
module tb;
    logic        clk_i, rst_i, nv_req_o, nv_ack_i, cfg_valid_o, cfg_error_o;
    logic        det_rst_en_o, det_int_en_o, s_axi_awvalid, s_axi_awready;
    logic        s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [1:0]  flash_mode_o, s_axi_bresp, s_axi_rresp, r;
    logic [3:0]  det_rst_lvl_o, det_int_lvl_o, s_axi_wstrb, nv_delay;
    logic [4:0]  osc_freq_mhz_o;
    logic [7:0]  nv_data_i, nv_det, nv_clk;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [19:0] nv_addr_o;
    logic [31:0] s_axi_wdata, s_axi_rdata, v;
    int          fail_count = 0, n_tests = 0, cycles = 0;

    obd_option_decoder u_dut (.clk_i(clk_i), .rst_i(rst_i), .nv_req_o(nv_req_o),
        .nv_addr_o(nv_addr_o), .nv_ack_i(nv_ack_i), .nv_data_i(nv_data_i),
        .cfg_valid_o(cfg_valid_o), .det_rst_en_o(det_rst_en_o), .det_int_en_o(det_int_en_o),
        .det_rst_lvl_o(det_rst_lvl_o), .det_int_lvl_o(det_int_lvl_o),
        .flash_mode_o(flash_mode_o), .osc_freq_mhz_o(osc_freq_mhz_o), .cfg_error_o(cfg_error_o),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready));
    obd_nv_model u_nv (.clk_i(clk_i), .rst_i(rst_i), .req_i(nv_req_o), .addr_i(nv_addr_o),
        .delay_i(nv_delay), .det_i(nv_det), .clkb_i(nv_clk), .ack_o(nv_ack_i),
        .data_o(nv_data_i));

    always #20 clk_i = ~clk_i;
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            fail_count++;
            give_verdict;
        end
    end

    task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wreg(input logic [11:0] a, input logic [31:0] d);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge clk_i);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_ok && w_ok))
        begin
            @(posedge clk_i);
            aw_ok = aw_ok | s_axi_awready;
            w_ok = w_ok | s_axi_wready;
            s_axi_awvalid <= !aw_ok;
            s_axi_wvalid <= !w_ok;
        end
        do @(posedge clk_i); while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic rreg(input logic [11:0] a);
        @(posedge clk_i);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge clk_i); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge clk_i); while (!s_axi_rvalid);
        v = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    // Resets, lets the bytes load, then checks the applied settings
    task automatic run_case(input logic [7:0] d, input logic [7:0] c, input logic [1:0] en,
                            input logic [3:0] rl, input logic [3:0] il, input logic [6:0] fx,
                            input logic e);
        nv_det <= d;
        nv_clk <= c;
        nv_delay <= nv_delay + 4'h3;
        rst_i <= 1'b1;
        @(posedge clk_i);
        rst_i <= 1'b0;
        do @(posedge clk_i); while (cfg_valid_o !== 1'b1);
        repeat (2) @(posedge clk_i);
        chk({det_rst_en_o, det_int_en_o}, en);
        if (en[1]) chk(det_rst_lvl_o, rl);
        if (en[0]) chk(det_int_lvl_o, il);
        chk({flash_mode_o, osc_freq_mhz_o}, fx);
        chk(cfg_error_o, e);
        rreg(12'h304);
        chk({r, v}, {26'h0, d});
        rreg(12'h308);
        chk({r, v}, {26'h0, c});
        rreg(12'h310);
        chk({r, v[0], |v[4:1], nv_req_o}, {2'h0, 1'b1, e, 1'b0});
    endtask

    task give_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial
    begin
        clk_i = 1'b0;
        rst_i = 1'b1;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 60'h0;
        {nv_delay, nv_det, nv_clk} = 20'h0;
        repeat (19) @(posedge clk_i);
        run_case(8'h1a, 8'h2d, 2'h3, 4'h0, 4'h1, {2'h0, 5'h01}, 1'b0);
        run_case(8'h36, 8'haa, 2'h3, 4'h2, 4'h4, {2'h2, 5'h08}, 1'b0);
        run_case(8'h52, 8'he0, 2'h3, 4'h5, 4'hc, {2'h3, 5'h18}, 1'b0);
        run_case(8'h7a, 8'he9, 2'h3, 4'h8, 4'h9, {2'h3, 5'h10}, 1'b0);
        run_case(8'h73, 8'he1, 2'h2, 4'hd, 4'h0, {2'h3, 5'h0c}, 1'b0);
        run_case(8'h33, 8'ha2, 2'h2, 4'hb, 4'h0, {2'h2, 5'h06}, 1'b0);
        run_case(8'h1d, 8'hab, 2'h1, 4'h0, 4'h0, {2'h2, 5'h04}, 1'b0);
        run_case(8'h51, 8'h23, 2'h1, 4'h0, 4'hc, {2'h0, 5'h03}, 1'b0);
        run_case(8'h9d, 8'h2c, 2'h0, 4'h0, 4'h0, {2'h0, 5'h02}, 1'b0);
        run_case(8'hf3, 8'h6d, 2'h0, 4'h0, 4'h0, {2'h0, 5'h01}, 1'b1);
        run_case(8'h1a, 8'he4, 2'h3, 4'h0, 4'h1, {2'h3, 5'h01}, 1'b1);
        run_case(8'h10, 8'h20, 2'h0, 4'h0, 4'h0, {2'h0, 5'h18}, 1'b1);
        run_case(8'h9e, 8'h2d, 2'h0, 4'h0, 4'h0, {2'h0, 5'h01}, 1'b1);
        run_case(8'h1e, 8'h2d, 2'h0, 4'h0, 4'h0, {2'h0, 5'h01}, 1'b1);
        run_case(8'h10, 8'h20, 2'h0, 4'h0, 4'h0, {2'h0, 5'h18}, 1'b1);
        rreg(12'h314);
        chk({r, v}, {2'h0, 32'h1});
        wreg(12'h314, 32'h0);
        chk(r, 2'h0);
        repeat (2) @(posedge clk_i);
        chk(cfg_error_o, 1'b0);
        wreg(12'h304, 32'hff);
        chk(r, 2'h2);
        rreg(12'h304);
        chk({r, v}, {2'h0, 32'h10});
        rreg(12'h400);
        chk({r, v}, {2'h2, 32'h0});
        wreg(12'h314, 32'h1);
        repeat (2) @(posedge clk_i);
        chk(cfg_error_o, 1'b1);
        give_verdict;
    end
endmodule // tb
`default_nettype wire
